// ### bench/crf_far_model.sv
// far-side model: instruction decoder and alu strobes into the register set
`timescale 1ns/100ps
module crf_far_model
(
  input  wire logic          i_sys_clk,
  output crf_pkg::crf_wr_t   o_wr,
  output crf_pkg::crf_alu_t  o_alu,
  output logic [4:0]         o_ev,
  output logic [19:0]        o_val
);
  // strobes idle from time zero so nothing is taken during reset
  initial
  begin
    o_wr = '0;
    o_alu = '0;
    o_ev = '0;
    o_val = '0;
  end

  // one pulse of strobes; the value bus is scrambled after it so no stale value passes
  task automatic step(input crf_pkg::crf_wr_t w, input crf_pkg::crf_alu_t a,
                      input logic [4:0] e, input logic [19:0] v);
    @(posedge i_sys_clk);
    o_wr <= w;
    o_alu <= a;
    o_ev <= e;
    o_val <= v;
    @(posedge i_sys_clk);
    o_wr <= '0;
    o_alu <= '0;
    o_ev <= '0;
    o_val <= ~v;
  endtask
endmodule

// ### bench/crf_top_asserts.sv
// checker: bus timing and flag relations at the ports of the register set
`timescale 1ns/100ps
module crf_top_asserts
(
  input wire logic                 i_sys_clk,
  input wire logic                 i_rstn,
  input wire crf_pkg::crf_wb_req_t i_wb,
  input wire logic                 o_wb_ack,
  input wire crf_pkg::crf_wr_t     i_dec_wr,
  input wire crf_pkg::crf_alu_t    i_alu,
  input wire logic                 i_insn_done,
  input wire logic                 i_hw_int_ack,
  input wire logic                 i_sstep_ack,
  input wire logic                 i_trap_exec,
  input wire logic [5:0]           i_trap_vec,
  input wire logic                 i_irq_req,
  input wire logic [2:0]           i_irq_prio,
  input wire crf_pkg::crf_view_t   o_view,
  input wire logic                 o_irq_accept,
  input wire logic                 o_sstep_req
);
  logic quiet;

  // flag side effects are judged only when no explicit write can override them
  assign quiet = !i_dec_wr.valid && !(i_wb.cyc && i_wb.stb && i_wb.we);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////
  chk_ack_next: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered on the next edge");
  chk_res_zero: assert property ((o_view.flags & ~crf_pkg::FLG_IMPL_MASK) == 16'h0000)
    else $error("reserved flag bit seen set");
  chk_sp_pick: assert property (
    o_view.sp == (o_view.flags[7] ? o_view.user_stack_pointer : o_view.interrupt_stack_pointer))
    else $error("active stack pointer does not follow the select flag");
  chk_pair_join: assert property (
    o_view.wide_data_pair_low == {o_view.data2, o_view.data0}
    && o_view.wide_data_pair_high == {o_view.data3, o_view.data1}
    && o_view.wide_address_pair == {o_view.addr1, o_view.addr0})
    else $error("wide register pair not made of its halves");
  chk_irq_gate: assert property (
    o_irq_accept == ($past(i_irq_req) && o_view.flags[6]
    && ($past(i_irq_prio) > o_view.flags[14:12])))
    else $error("interrupt accept disagrees with enable and level");
  chk_step_req: assert property (
    o_sstep_req == ($past(i_insn_done) && o_view.flags[1]))
    else $error("single step request disagrees with debug flag");
  chk_carry_upd: assert property (
    quiet && i_alu.upd_c |=> ##1 o_view.flags[0] == $past(i_alu.c, 2))
    else $error("carry flag did not take the alu value");
  chk_zero_upd: assert property (
    quiet && i_alu.upd_z |=> ##1 o_view.flags[2] == $past(i_alu.z, 2))
    else $error("zero flag did not take the alu value");
  chk_ack_clear: assert property (
    quiet && i_hw_int_ack |=> ##1 o_view.flags[7:6] == 2'b00)
    else $error("interrupt ack left enable or stack select set");
  chk_trap_low: assert property (
    quiet && i_trap_exec && i_trap_vec <= crf_pkg::TRAP_ISP_MAX |=> ##1 !o_view.flags[7])
    else $error("low trap vector left stack select set");
  chk_step_clear: assert property (quiet && i_sstep_ack |=> ##1 !o_view.flags[1])
    else $error("single step ack left debug flag set");

  // main scenarios reached
  cover property (o_irq_accept);
  cover property (o_sstep_req);
  cover property (quiet && i_hw_int_ack);
endmodule

// ### bench/test_crf_top.sv
// testbench: bus, decoder, alu and interrupt scenarios for the register set
`timescale 1ns/100ps
module test_crf_top;
  logic                 clk = 1'b0;
  logic                 rstn = 1'b0;
  crf_pkg::crf_wb_req_t wbr = '0;
  crf_pkg::crf_wr_t     wr;
  crf_pkg::crf_alu_t    alu;
  logic [4:0]           ev;
  logic [19:0]          val;
  logic                 irq = 1'b0;
  logic [2:0]           prio = 3'h0;
  logic                 ack;
  logic [31:0]          rdat;
  crf_pkg::crf_view_t   view;
  logic                 acc;
  logic                 sreq;
  logic [31:0]          q;
  int                   n_mismatch = 0;
  int                   checked = 0;
  int                   cycles = 0;

  crf_top u_crf_top (.i_sys_clk(clk), .i_rstn(rstn), .i_wb(wbr), .o_wb_ack(ack), .o_wb_dat(rdat),
    .i_dec_wr(wr), .i_alu(alu), .i_iptr_load(ev[0]), .i_iptr_next(val), .i_insn_done(ev[4]),
    .i_hw_int_ack(ev[3]), .i_sstep_ack(ev[2]), .i_trap_exec(ev[1]), .i_trap_vec(val[5:0]),
    .i_irq_req(irq), .i_irq_prio(prio), .o_view(view), .o_irq_accept(acc), .o_sstep_req(sreq));
  crf_far_model u_crf_far_model (.i_sys_clk(clk), .o_wr(wr), .o_alu(alu), .o_ev(ev), .o_val(val));

  // 100 MHz clock
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  // classic cycle; the request stands until ack is sampled high at a rising edge,
  // read data is taken at that same edge and only then is the request dropped
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk);
    wbr <= '{1'b1, 1'b1, w, a, s, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    wbr.cyc <= 1'b0;
    wbr.stb <= 1'b0;
  endtask

  task automatic st;
    repeat (2) @(negedge clk);
  endtask

  task automatic dw(input crf_pkg::crf_sel_t s, input crf_pkg::crf_size_t z, input logic [31:0] d);
    crf_pkg::crf_wr_t w;
    w = '{1'b1, s, z, d};
    u_crf_far_model.step(w, '0, '0, '0);
  endtask

  task automatic pe(input logic [4:0] e, input logic [19:0] v);
    u_crf_far_model.step('0, '0, e, v);
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(1'b0, 8'h54, 4'hF, 32'h0);
    chk("flags reset", q, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      wb(1'b1, 8'(4 * i), 4'h3, 32'h1100 + i);
      wb(1'b1, 8'(8'h20 + 4 * i), 4'h3, 32'h2200 + i);
    end
    wb(1'b1, 8'h1C, 4'hF, 32'hFFFF);
    wb(1'b0, 8'h1C, 4'hF, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b1, 8'h40, 4'hF, 32'hABCDE);
    wb(1'b0, 8'h40, 4'hF, 32'h0);
    chk("iptr ro", q, 32'h0);
    wb(1'b1, 8'h44, 4'hF, 32'hFFFFFFFF);
    wb(1'b0, 8'h44, 4'hF, 32'h0);
    chk("vtb", q, 32'h000FFFFF);
    wb(1'b0, 8'h0C, 4'hF, 32'h0);
    chk("data3", q, 32'h1103);
    wb(1'b1, 8'h50, 4'h3, 32'h5B5B);
    st();
    chk("sb", view.sb, 32'h5B5B);
    chk("view vtb", view.vtb, 32'h000FFFFF);
    chk("bank0 fb", view.fb, 32'h1106);
    wb(1'b1, 8'h54, 4'hF, 32'h10);
    st();
    chk("bank1 data0", view.data0, 32'h2200);
    chk("bank1 fb", view.fb, 32'h2206);
    wb(1'b1, 8'h54, 4'hF, 32'h0);
  endtask

  task automatic t_dec;
    dw(crf_pkg::SEL_DATA0, crf_pkg::SZ_DWORD, 32'hA5A55A5A);
    dw(crf_pkg::SEL_DATA1, crf_pkg::SZ_HI, 32'h3C);
    dw(crf_pkg::SEL_DATA1, crf_pkg::SZ_LO, 32'h5A);
    dw(crf_pkg::SEL_ADDR0, crf_pkg::SZ_DWORD, 32'h12345678);
    dw(crf_pkg::SEL_SP, crf_pkg::SZ_WORD, 32'h4321);
    st();
    chk("pair low", view.wide_data_pair_low, 32'hA5A55A5A);
    chk("data1 halves", view.data1, 32'h3C5A);
    chk("pair high", view.wide_data_pair_high, 32'h11033C5A);
    chk("addr pair", view.wide_address_pair, 32'h12345678);
    chk("isp", view.interrupt_stack_pointer, 32'h4321);
    wb(1'b1, 8'h48, 4'h3, 32'h7777);
    wb(1'b1, 8'h54, 4'hF, 32'h80);
    st();
    chk("sp user", view.sp, 32'h7777);
  endtask

  task automatic t_flags;
    crf_pkg::crf_wr_t w;
    u_crf_far_model.step('0, 8'hFF, '0, '0);
    st();
    chk("alu set", view.flags, 32'h00AD);
    u_crf_far_model.step('0, 8'hAA, '0, '0);
    st();
    chk("alu clear", view.flags, 32'h0080);
    wb(1'b1, 8'h54, 4'hF, 32'hFFFF);
    wb(1'b0, 8'h54, 4'hF, 32'h0);
    chk("reserved", q, 32'h70FF);
    w = '{1'b1, crf_pkg::SEL_FLAGS, crf_pkg::SZ_WORD, 32'h0};
    u_crf_far_model.step(w, 8'h30, '0, '0);
    st();
    chk("write wins", view.flags, 32'h0);
  endtask

  task automatic t_irq;
    wb(1'b1, 8'h54, 4'hF, 32'h30C0);
    irq <= 1'b1;
    prio <= 3'h3;
    st();
    chk("equal prio", acc, 32'h0);
    @(posedge clk);
    prio <= 3'h4;
    st();
    chk("higher prio", acc, 32'h1);
    wb(1'b1, 8'h54, 4'hF, 32'h3080);
    st();
    chk("masked", acc, 32'h0);
    @(posedge clk);
    irq <= 1'b0;
    wb(1'b1, 8'h54, 4'hF, 32'h30C0);
    pe(5'h08, 20'h0);
    st();
    chk("hw ack", view.flags, 32'h3000);
    wb(1'b1, 8'h54, 4'hF, 32'h80);
    pe(5'h02, 20'd32);
    st();
    chk("trap 32", view.flags, 32'h80);
    pe(5'h02, 20'd31);
    st();
    chk("trap 31", view.flags, 32'h0);
  endtask

  task automatic t_step;
    wb(1'b1, 8'h54, 4'hF, 32'h2);
    pe(5'h10, 20'h0);
    @(negedge clk);
    chk("step req", sreq, 32'h1);
    pe(5'h04, 20'h0);
    st();
    chk("step ack", view.flags, 32'h0);
    pe(5'h01, 20'hABCDE);
    st();
    chk("iptr", view.iptr, 32'hABCDE);
  endtask

  // reset, then every scenario in turn
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_dec();
    t_flags();
    t_irq();
    t_step();
    test_done();
  end
endmodule

bind crf_top crf_top_asserts u_crf_top_asserts (.i_sys_clk, .i_rstn, .i_wb, .o_wb_ack, .i_dec_wr,
  .i_alu, .i_insn_done, .i_hw_int_ack, .i_sstep_ack, .i_trap_exec, .i_trap_vec, .i_irq_req,
  .i_irq_prio, .o_view, .o_irq_accept, .o_sstep_req);

// ### src/crf_bank.sv
// module: two banks of seven 16-bit registers with per-byte write enables
`timescale 1ns/100ps
module crf_bank
(
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rstn,
  input  wire logic [1:0][6:0][1:0]    i_be,
  input  wire logic [1:0][6:0][15:0]   i_wdata,
  output logic      [1:0][6:0][15:0]   o_q
);

  ////////////////////////////////////////////////////////////////////////////
  // one flop group per bank, entry and byte lane
  genvar gb, ge, gl;
  generate
    for (gb = 0; gb < 2; gb++)
    begin : g_bank
      for (ge = 0; ge < 7; ge++)
      begin : g_entry
        for (gl = 0; gl < 2; gl++)
        begin : g_lane
          // a lane only moves when its own enable is set, so byte halves stay independent
          always_ff @(posedge i_sys_clk or negedge i_rstn)
          begin
            if (!i_rstn)
            begin
              o_q[gb][ge][gl*8 +: 8] <= crf_pkg::RST_WORD[gl*8 +: 8];
            end
            else if (i_be[gb][ge][gl])
            begin
              o_q[gb][ge][gl*8 +: 8] <= i_wdata[gb][ge][gl*8 +: 8];
            end
          end
        end
      end
    end
  endgenerate

endmodule

// ### src/crf_pkg.sv
// package: register map, flag layout, reset values and carrier types of the cpu register set
package crf_pkg;

  // bank geometry
  localparam int unsigned NUM_BANKS   = 2;
  localparam int unsigned NUM_BANKED  = 7;

  // flag bit positions
  localparam int unsigned FLG_CARRY   = 0;
  localparam int unsigned FLG_DEBUG   = 1;
  localparam int unsigned FLG_ZERO    = 2;
  localparam int unsigned FLG_SIGN    = 3;
  localparam int unsigned FLG_BANK    = 4;
  localparam int unsigned FLG_OVFL    = 5;
  localparam int unsigned FLG_IEN     = 6;
  localparam int unsigned FLG_STACK   = 7;
  localparam int unsigned FLG_PPL_LSB = 12;
  localparam int unsigned FLG_PPL_MSB = 14;
  localparam logic [15:0] FLG_IMPL_MASK = 16'h70FF;

  // reset values
  localparam logic [15:0] RST_WORD    = 16'h0000;
  localparam logic [19:0] RST_ADDR20  = 20'h00000;
  localparam logic [15:0] RST_FLAGS   = 16'h0000;

  // highest software trap vector that forces the interrupt stack
  localparam logic [5:0]  TRAP_ISP_MAX = 6'h1F;

  // wishbone byte offsets
  localparam logic [7:0]  OFS_BANK0   = 8'h00;
  localparam logic [7:0]  OFS_BANK1   = 8'h20;
  localparam logic [7:0]  OFS_IPTR    = 8'h40;
  localparam logic [7:0]  OFS_VTB     = 8'h44;
  localparam logic [7:0]  OFS_USP     = 8'h48;
  localparam logic [7:0]  OFS_ISP     = 8'h4C;
  localparam logic [7:0]  OFS_SB      = 8'h50;
  localparam logic [7:0]  OFS_FLAGS   = 8'h54;

  // decoder write target; the first seven match the bank entry index
  typedef enum logic [3:0] {
    SEL_DATA0, SEL_DATA1, SEL_DATA2, SEL_DATA3, SEL_ADDR0, SEL_ADDR1, SEL_FB,
    SEL_VTB, SEL_USP, SEL_ISP, SEL_SP, SEL_SB, SEL_FLAGS
  } crf_sel_t;

  typedef enum logic [1:0] {SZ_LO, SZ_HI, SZ_WORD, SZ_DWORD} crf_size_t;

  typedef struct packed {
    logic        valid;
    crf_sel_t    sel;
    crf_size_t   size;
    logic [31:0] data;
  } crf_wr_t;

  typedef struct packed {
    logic upd_c;
    logic c;
    logic upd_z;
    logic z;
    logic upd_s;
    logic s;
    logic upd_o;
    logic o;
  } crf_alu_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } crf_wb_req_t;

  typedef struct packed {
    logic [15:0] data0;
    logic [15:0] data1;
    logic [15:0] data2;
    logic [15:0] data3;
    logic [15:0] addr0;
    logic [15:0] addr1;
    logic [15:0] fb;
    logic [19:0] iptr;
    logic [19:0] vtb;
    logic [15:0] user_stack_pointer;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] sp;
    logic [15:0] sb;
    logic [15:0] flags;
    logic [31:0] wide_data_pair_low;
    logic [31:0] wide_data_pair_high;
    logic [31:0] wide_address_pair;
  } crf_view_t;

endpackage

// ### src/crf_top.sv
// module: cpu architectural register set, flags and interrupt gating with wishbone access
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module crf_top
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rstn,
  input  wire crf_pkg::crf_wb_req_t  i_wb,
  output logic                       o_wb_ack,
  output logic [31:0]                o_wb_dat,
  input  wire crf_pkg::crf_wr_t      i_dec_wr,
  input  wire crf_pkg::crf_alu_t     i_alu,
  input  wire logic                  i_iptr_load,
  input  wire logic [19:0]           i_iptr_next,
  input  wire logic                  i_insn_done,
  input  wire logic                  i_hw_int_ack,
  input  wire logic                  i_sstep_ack,
  input  wire logic                  i_trap_exec,
  input  wire logic [5:0]            i_trap_vec,
  input  wire logic                  i_irq_req,
  input  wire logic [2:0]            i_irq_prio,
  output crf_pkg::crf_view_t         o_view,
  output logic                       o_irq_accept,
  output logic                       o_sstep_req
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0][6:0][15:0] bank_q;
  logic [1:0][6:0][1:0]  next_be;
  logic [1:0][6:0][15:0] next_wd;
  logic [19:0]           iptr;
  logic [19:0]           vtb;
  logic [15:0]           user_stack_pointer;
  logic [15:0]           interrupt_stack_pointer;
  logic [15:0]           sb;
  logic [15:0]           flags;
  logic [15:0]           next_flags;
  logic                  bank_sel;
  logic                  stack_sel;
  logic [2:0]            ppl;

  assign bank_sel  = flags[crf_pkg::FLG_BANK];
  assign stack_sel = flags[crf_pkg::FLG_STACK];
  assign ppl       = flags[crf_pkg::FLG_PPL_MSB:crf_pkg::FLG_PPL_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode; a request is taken once, in the cycle before ack rises
  logic       bus_go;
  logic       bus_wr;
  logic       bus_banked;
  logic       bus_bank;
  logic [2:0] bus_idx;
  logic       wr_vtb;
  logic       wr_usp;
  logic       wr_isp;
  logic       wr_sb;
  logic       wr_flg;

  assign bus_go     = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign bus_wr     = bus_go && i_wb.we;
  assign bus_bank   = i_wb.adr[5];
  assign bus_idx    = i_wb.adr[4:2];
  assign bus_banked = (i_wb.adr[7:6] == 2'h0) && (bus_idx != 3'h7);
  assign wr_vtb     = bus_wr && (i_wb.adr == crf_pkg::OFS_VTB);
  assign wr_usp     = bus_wr && (i_wb.adr == crf_pkg::OFS_USP);
  assign wr_isp     = bus_wr && (i_wb.adr == crf_pkg::OFS_ISP);
  assign wr_sb      = bus_wr && (i_wb.adr == crf_pkg::OFS_SB);
  assign wr_flg     = bus_wr && (i_wb.adr == crf_pkg::OFS_FLAGS);

  ////////////////////////////////////////////////////////////////////////////
  // decoder write decode
  logic dec_word;
  logic dec_vtb;
  logic dec_usp;
  logic dec_isp;
  logic dec_sb;
  logic dec_flg;

  // only whole-word writes reach non-banked registers; byte forms go to data zero/one only
  assign dec_word = i_dec_wr.valid && (i_dec_wr.size != crf_pkg::SZ_LO)
                    && (i_dec_wr.size != crf_pkg::SZ_HI);
  assign dec_vtb  = dec_word && (i_dec_wr.sel == crf_pkg::SEL_VTB);
  assign dec_usp  = dec_word && ((i_dec_wr.sel == crf_pkg::SEL_USP)
                    || ((i_dec_wr.sel == crf_pkg::SEL_SP) && stack_sel));
  assign dec_isp  = dec_word && ((i_dec_wr.sel == crf_pkg::SEL_ISP)
                    || ((i_dec_wr.sel == crf_pkg::SEL_SP) && !stack_sel));
  assign dec_sb   = dec_word && (i_dec_wr.sel == crf_pkg::SEL_SB);
  assign dec_flg  = dec_word && (i_dec_wr.sel == crf_pkg::SEL_FLAGS);

  // partner entry that carries the upper half of a 32-bit register
  function automatic logic [3:0] upper_of(input logic [2:0] idx);
    logic [3:0] r;
    r = 4'hF;
    if (idx == 3'h0)
    begin
      r = 4'h2;
    end
    else if (idx == 3'h1)
    begin
      r = 4'h3;
    end
    else if (idx == 3'h4)
    begin
      r = 4'h5;
    end
    upper_of = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // banked write enables; decoder targets the active bank, the bus names its bank
  always_comb
  begin
    logic [2:0] di;
    logic [3:0] up;
    next_be = '0;
    next_wd = '0;
    di      = i_dec_wr.sel[2:0];
    up      = upper_of(di);
    if (i_dec_wr.valid && (i_dec_wr.sel <= crf_pkg::SEL_FB))
    begin
      unique case (i_dec_wr.size)
        crf_pkg::SZ_LO:
        begin
          if (di <= 3'h1)
          begin
            next_be[bank_sel][di] = 2'b01;
            next_wd[bank_sel][di] = {2{i_dec_wr.data[7:0]}};
          end
        end
        crf_pkg::SZ_HI:
        begin
          if (di <= 3'h1)
          begin
            next_be[bank_sel][di] = 2'b10;
            next_wd[bank_sel][di] = {2{i_dec_wr.data[7:0]}};
          end
        end
        crf_pkg::SZ_WORD:
        begin
          next_be[bank_sel][di] = 2'b11;
          next_wd[bank_sel][di] = i_dec_wr.data[15:0];
        end
        crf_pkg::SZ_DWORD:
        begin
          // the higher-numbered register takes the upper half
          if (up != 4'hF)
          begin
            next_be[bank_sel][di]      = 2'b11;
            next_wd[bank_sel][di]      = i_dec_wr.data[15:0];
            next_be[bank_sel][up[2:0]] = 2'b11;
            next_wd[bank_sel][up[2:0]] = i_dec_wr.data[31:16];
          end
        end
      endcase
    end
    // bus wins a same-cycle collision on the same entry
    if (bus_wr && bus_banked)
    begin
      next_be[bus_bank][bus_idx] = i_wb.sel[1:0];
      next_wd[bus_bank][bus_idx] = i_wb.dat[15:0];
    end
  end

  crf_bank u_bank
  (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_be      (next_be),
    .i_wdata   (next_wd),
    .o_q       (bank_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // instruction pointer; software can only read it
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      iptr <= crf_pkg::RST_ADDR20;
    end
    else if (i_iptr_load)
    begin
      iptr <= i_iptr_next;
    end
  end

  // vector table base; bus byte lanes 0 to 2 cover the 20 bits
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      vtb <= crf_pkg::RST_ADDR20;
    end
    else if (wr_vtb)
    begin
      if (i_wb.sel[0]) vtb[7:0]   <= i_wb.dat[7:0];
      if (i_wb.sel[1]) vtb[15:8]  <= i_wb.dat[15:8];
      if (i_wb.sel[2]) vtb[19:16] <= i_wb.dat[19:16];
    end
    else if (dec_vtb)
    begin
      vtb <= i_dec_wr.data[19:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointers and static base
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      user_stack_pointer <= crf_pkg::RST_WORD;
      interrupt_stack_pointer <= crf_pkg::RST_WORD;
    end
    else
    begin
      if (wr_usp)
      begin
        if (i_wb.sel[0]) user_stack_pointer[7:0]  <= i_wb.dat[7:0];
        if (i_wb.sel[1]) user_stack_pointer[15:8] <= i_wb.dat[15:8];
      end
      else if (dec_usp)
      begin
        user_stack_pointer <= i_dec_wr.data[15:0];
      end
      if (wr_isp)
      begin
        if (i_wb.sel[0]) interrupt_stack_pointer[7:0]  <= i_wb.dat[7:0];
        if (i_wb.sel[1]) interrupt_stack_pointer[15:8] <= i_wb.dat[15:8];
      end
      else if (dec_isp)
      begin
        interrupt_stack_pointer <= i_dec_wr.data[15:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sb <= crf_pkg::RST_WORD;
    end
    else if (wr_sb)
    begin
      if (i_wb.sel[0]) sb[7:0]  <= i_wb.dat[7:0];
      if (i_wb.sel[1]) sb[15:8] <= i_wb.dat[15:8];
    end
    else if (dec_sb)
    begin
      sb <= i_dec_wr.data[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags: explicit write, else alu results followed by acknowledge clears
  always_comb
  begin
    next_flags = flags;
    if (wr_flg)
    begin
      if (i_wb.sel[0]) next_flags[7:0]  = i_wb.dat[7:0];
      if (i_wb.sel[1]) next_flags[15:8] = i_wb.dat[15:8];
    end
    else if (dec_flg)
    begin
      next_flags = i_dec_wr.data[15:0];
    end
    else
    begin
      if (i_alu.upd_c) next_flags[crf_pkg::FLG_CARRY] = i_alu.c;
      if (i_alu.upd_z) next_flags[crf_pkg::FLG_ZERO]  = i_alu.z;
      if (i_alu.upd_s) next_flags[crf_pkg::FLG_SIGN]  = i_alu.s;
      if (i_alu.upd_o) next_flags[crf_pkg::FLG_OVFL]  = i_alu.o;
      if (i_sstep_ack)
      begin
        next_flags[crf_pkg::FLG_DEBUG] = 1'b0;
      end
      if (i_hw_int_ack || i_sstep_ack)
      begin
        next_flags[crf_pkg::FLG_IEN]   = 1'b0;
        next_flags[crf_pkg::FLG_STACK] = 1'b0;
      end
      if (i_trap_exec && (i_trap_vec <= crf_pkg::TRAP_ISP_MAX))
      begin
        next_flags[crf_pkg::FLG_STACK] = 1'b0;
      end
    end
    // reserved positions never hold a one
    next_flags = next_flags & crf_pkg::FLG_IMPL_MASK;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      flags <= crf_pkg::RST_FLAGS;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt gating and single-step request, registered for clean outputs
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq_accept <= 1'b0;
      o_sstep_req  <= 1'b0;
    end
    else
    begin
      o_irq_accept <= i_irq_req && flags[crf_pkg::FLG_IEN]
                      && (i_irq_prio > ppl);
      o_sstep_req  <= i_insn_done && flags[crf_pkg::FLG_DEBUG];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register view toward decoder and alu; trails the state by one cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_view <= '0;
    end
    else
    begin
      o_view.data0 <= bank_q[bank_sel][0];
      o_view.data1 <= bank_q[bank_sel][1];
      o_view.data2 <= bank_q[bank_sel][2];
      o_view.data3 <= bank_q[bank_sel][3];
      o_view.addr0 <= bank_q[bank_sel][4];
      o_view.addr1 <= bank_q[bank_sel][5];
      o_view.fb    <= bank_q[bank_sel][6];
      o_view.iptr  <= iptr;
      o_view.vtb   <= vtb;
      o_view.user_stack_pointer   <= user_stack_pointer;
      o_view.interrupt_stack_pointer   <= interrupt_stack_pointer;
      o_view.sp    <= stack_sel ? user_stack_pointer : interrupt_stack_pointer;
      o_view.sb    <= sb;
      o_view.flags <= flags;
      o_view.wide_data_pair_low  <= {bank_q[bank_sel][2], bank_q[bank_sel][0]};
      o_view.wide_data_pair_high <= {bank_q[bank_sel][3], bank_q[bank_sel][1]};
      o_view.wide_address_pair   <= {bank_q[bank_sel][5], bank_q[bank_sel][4]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read mux; unmapped addresses read zero and still acknowledge
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (bus_banked)
    begin
      rd_mux = {16'h0000, bank_q[bus_bank][bus_idx]};
    end
    else
    begin
      unique case (i_wb.adr)
        crf_pkg::OFS_IPTR:  rd_mux = {12'h000, iptr};
        crf_pkg::OFS_VTB:   rd_mux = {12'h000, vtb};
        crf_pkg::OFS_USP:   rd_mux = {16'h0000, user_stack_pointer};
        crf_pkg::OFS_ISP:   rd_mux = {16'h0000, interrupt_stack_pointer};
        crf_pkg::OFS_SB:    rd_mux = {16'h0000, sb};
        crf_pkg::OFS_FLAGS: rd_mux = {16'h0000, flags};
        default:            rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ack for exactly one cycle, one edge after the request is seen
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= bus_go;
      if (bus_go && !i_wb.we)
      begin
        o_wb_dat <= rd_mux;
      end
    end
  end

endmodule
